/* File: inc/wpr_pkg.sv */
/*
  Shared constants and types for the watchdog, power and reset block.
  Assumes APB with 32-bit data; registers sit at four times their index.
*/
`default_nettype none
package wpr_pkg;
  // Register indices and the byte addresses derived from them.
  localparam int unsigned APB_AW = 12;
  localparam logic [7:0] POWER_CONTROL_IDX = 8'h87;
  localparam logic [7:0] WATCHDOG_CONTROL_IDX = 8'h8f;
  localparam logic [11:0] POWER_CONTROL_ADDR = {2'h0, POWER_CONTROL_IDX, 2'h0};
  localparam logic [11:0] WATCHDOG_CONTROL_ADDR = {2'h0, WATCHDOG_CONTROL_IDX, 2'h0};

  // Machine cycle: six states of two oscillator periods each.
  localparam logic [2:0] STATE_LAST = 3'h5;
  localparam logic [2:0] SAMPLE_STATE = 3'h4;
  localparam int unsigned OSC_PER_MC = 12;
  localparam int unsigned WDT_BITS = 14;
  localparam int unsigned PRE_BITS = 8;
  localparam int unsigned RST_SAMPLES = 2;

  // Reset values for the wider chip and for this block.
  localparam logic [7:0] PORT_RST = 8'hff;
  localparam logic [7:0] SP_RST = 8'h07;
  localparam logic [7:0] SFR_RST = 8'h00;

  // Watchdog control layout.
  typedef struct packed {
    logic wdog_enable_bit;
    logic wdog_clear_bit;
    logic wdog_run_in_idle;
    logic [1:0] rsv;
    logic [2:0] wdog_prescale_select;
  } wpr_watchdog_control_type;

  // Power control layout.
  typedef struct packed {
    logic [2:0] rsv;
    logic power_off_flag;
    logic user_flag_one;
    logic user_flag_zero;
    logic power_down_bit;
    logic idle_bit;
  } wpr_power_control_type;

  localparam wpr_watchdog_control_type WATCHDOG_CONTROL_RST = wpr_watchdog_control_type'(SFR_RST);
  localparam wpr_power_control_type POWER_CONTROL_POR = wpr_power_control_type'(8'h10);

  // Power modes.
  typedef enum logic [1:0] {WPR_RUN, WPR_IDLE, WPR_PDOWN} wpr_mode_type;

  // APB request and answer bundles.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata;
  } wpr_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } wpr_apb_rsp_type;

  // Last prescaler count for each select code; 010 and 001 are swapped.
  function automatic logic [PRE_BITS-1:0] wpr_pre_last(input logic [2:0] code);
    logic [PRE_BITS-1:0] r;
    r = 8'h01;
    case (code)
      3'h0: r = 8'h01;
      3'h2: r = 8'h03;
      3'h1: r = 8'h07;
      3'h3: r = 8'h0f;
      3'h4: r = 8'h1f;
      3'h5: r = 8'h3f;
      3'h6: r = 8'h7f;
      default: r = 8'hff;
    endcase
    return r;
  endfunction
endpackage
`default_nettype wire

/* File: hdl/wpr_rst_filter.sv */
/*
  Reset pin deglitch filter: counts consecutive high samples.
  Assumes a synchronised level and a one-cycle sample strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module wpr_rst_filter #(
  parameter int unsigned SAMPLES = wpr_pkg::RST_SAMPLES
) (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Sample strobe and level.
  input wire logic i_sample,
  input wire logic i_level,
  // Filtered reset request.
  output logic o_rst
);
  localparam int unsigned CW = $clog2(SAMPLES + 1);
  localparam logic [CW-1:0] CMAX = CW'(SAMPLES);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic rst_ff;

  // A low sample restarts the count, so short glitches never reach the top.
  assign nxt_cnt = !i_sample ? cnt_ff :
                   !i_level ? '0 :
                   (cnt_ff == CMAX) ? cnt_ff : cnt_ff + CW'(1);

  // Count and output registers.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_ff <= '0;
      rst_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      rst_ff <= (nxt_cnt == CMAX);
    end
  end

  assign o_rst = rst_ff;
endmodule
`default_nettype wire

/* File: hdl/wpr_watchdog_power_reset.sv */
/*
  Watchdog timer, idle and power-down control, reset sampling and the
  power and watchdog control registers, reached over APB.
  Assumes i_ref_clk is the oscillator and i_rst_b is the power-on reset.
  The reset pin is asynchronous; the interrupt request is synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
//
// Overview of operation
// - Watchdog is disabled after every reset.
// - Enable bit starts counting and arms reset; clearing it disables.
// - Time-out while enabled raises an internal system reset.
// - Period is 2^14 times prescale ratio times 12 oscillator periods.
// - Select codes map to ratios 2..256, with 010 and 001 swapped.
// - Clear bit resets timer, prescaler and itself next machine cycle.
// - Watchdog counts in idle only when run-in-idle is set.
// - Any reset zeroes the watchdog timer and prescaler.
// - Oscillator clock is divided by two before internal use.
// - Idle stops the core clock; peripherals keep running.
// - Idle ends on an enabled interrupt or on reset.
// - Power-down stops every clock including the oscillator.
// - Only a reset ends power-down; interrupts do not.
// - Power-off flag set at power-on, cleared by software only.
// - Two user flags just store what software writes.
// - Reset pin sampled once per machine cycle, needs two high samples.
// - Short glitches on the reset pin are ignored.
// - Reset sets registers to zero, except the power-off flag.
module wpr_watchdog_power_reset (
  // Clock and power-on reset.
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // APB slave.
  input wire wpr_pkg::wpr_apb_req_type i_apb_req,
  output wpr_pkg::wpr_apb_rsp_type o_apb_rsp,
  // Reset pin and enabled interrupt request.
  input wire logic i_rst_pin,
  input wire logic i_irq_pend,
  // Clock control and system reset.
  output logic o_osc_run,
  output logic o_cpu_clk_en,
  output logic o_periph_clk_en,
  output logic o_mc_tick,
  output logic o_sys_rst,
  output logic o_wdt_timeout
);
  // State.
  logic phase_ff;
  logic [2:0] state_ff;
  logic pin_meta_ff;
  logic pin_sync_ff;
  logic wdt_rst_ff;
  logic sys_rst_ff;
  logic to_ff;
  logic [wpr_pkg::PRE_BITS-1:0] pre_ff;
  logic [wpr_pkg::WDT_BITS-1:0] timer_ff;
  logic [31:0] prdata_ff;
  wpr_pkg::wpr_watchdog_control_type watchdog_control_ff;
  wpr_pkg::wpr_power_control_type power_control_ff;
  wpr_pkg::wpr_mode_type mode_ff;

  // Next values and decode.
  logic [2:0] nxt_state;
  logic [wpr_pkg::PRE_BITS-1:0] nxt_pre;
  logic [wpr_pkg::WDT_BITS-1:0] nxt_timer;
  logic [wpr_pkg::PRE_BITS-1:0] pre_last;
  wpr_pkg::wpr_watchdog_control_type nxt_watchdog_control;
  wpr_pkg::wpr_power_control_type nxt_power_control;
  wpr_pkg::wpr_watchdog_control_type wr_watchdog_control_val;
  wpr_pkg::wpr_power_control_type wr_power_control_val;
  wpr_pkg::wpr_mode_type nxt_mode;
  logic mc_tick;
  logic sample;
  logic pin_rst;
  logic wdt_run;
  logic pre_wrap;
  logic wdt_to;
  logic clr_do;
  logic idle_exit;
  logic setup;
  logic access;
  logic power_control_hit;
  logic watchdog_control_hit;
  logic wr_power_control;
  logic wr_watchdog_control;
  logic [7:0] rd_val;

  // Oscillator runs unless powered down; a high pin restarts it.
  // stop all clocks
  assign o_osc_run = (mode_ff != wpr_pkg::WPR_PDOWN) || pin_sync_ff;

  // Two oscillator periods make one state, six states a machine cycle.
  // divide by two
  assign nxt_state = !phase_ff ? state_ff :
                     (state_ff == wpr_pkg::STATE_LAST) ? 3'h0 : state_ff + 3'h1;
  assign mc_tick = o_osc_run && phase_ff && (state_ff == wpr_pkg::STATE_LAST);
  assign sample = o_osc_run && phase_ff && (state_ff == wpr_pkg::SAMPLE_STATE);

  // Divider registers, frozen while the oscillator is stopped.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      phase_ff <= 1'b0;
      state_ff <= 3'h0;
    end else if (o_osc_run) begin
      phase_ff <= ~phase_ff;
      state_ff <= nxt_state;
    end
  end

  // Reset pin passes two flip-flops before anything reads it.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_meta_ff <= 1'b0;
      pin_sync_ff <= 1'b0;
    end else begin
      pin_meta_ff <= i_rst_pin;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  wpr_rst_filter #(
    .SAMPLES(wpr_pkg::RST_SAMPLES)
  ) u_rst_filter (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_sample(sample),
    .i_level(pin_sync_ff),
    .o_rst(pin_rst)
  );

  // Watchdog counts machine cycles when enabled and not parked.
  // enable gates count
  assign wdt_run = watchdog_control_ff.wdog_enable_bit && mc_tick &&
                   (mode_ff != wpr_pkg::WPR_PDOWN) &&
                   ((mode_ff != wpr_pkg::WPR_IDLE) || watchdog_control_ff.wdog_run_in_idle);

  assign pre_last = wpr_pkg::wpr_pre_last(watchdog_control_ff.wdog_prescale_select);

  assign pre_wrap = wdt_run && (pre_ff == pre_last);
  assign wdt_to = pre_wrap && (timer_ff == {wpr_pkg::WDT_BITS{1'b1}});

  assign clr_do = watchdog_control_ff.wdog_clear_bit && mc_tick;

  assign nxt_pre = (sys_rst_ff || clr_do) ? '0 :
                   pre_wrap ? '0 :
                   wdt_run ? pre_ff + 8'h01 : pre_ff;
  assign nxt_timer = (sys_rst_ff || clr_do) ? '0 :
                     pre_wrap ? timer_ff + 14'h0001 : timer_ff;

  // Watchdog counters.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pre_ff <= '0;
      timer_ff <= '0;
    end else begin
      pre_ff <= nxt_pre;
      timer_ff <= nxt_timer;
    end
  end

  // Time-out reset lasts one machine cycle, then joins the pin reset.
  // time-out resets
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wdt_rst_ff <= 1'b0;
      sys_rst_ff <= 1'b0;
      to_ff <= 1'b0;
    end else begin
      wdt_rst_ff <= wdt_to || (wdt_rst_ff && !mc_tick);
      sys_rst_ff <= pin_rst || wdt_rst_ff;
      to_ff <= wdt_to;
    end
  end

  // Power mode sequencing.
  // interrupt ends idle
  assign idle_exit = (mode_ff == wpr_pkg::WPR_IDLE) && i_irq_pend;
  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      wpr_pkg::WPR_RUN: begin
        if (power_control_ff.power_down_bit) begin
          nxt_mode = wpr_pkg::WPR_PDOWN;
        end else if (power_control_ff.idle_bit) begin
          nxt_mode = wpr_pkg::WPR_IDLE;
        end
      end
      wpr_pkg::WPR_IDLE: begin
        if (i_irq_pend) begin
          nxt_mode = wpr_pkg::WPR_RUN;
        end
      end
      default: begin
        nxt_mode = wpr_pkg::WPR_PDOWN;
      end
    endcase
    if (sys_rst_ff) begin
      nxt_mode = wpr_pkg::WPR_RUN;
    end
  end

  // Mode register.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_ff <= wpr_pkg::WPR_RUN;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // Clock gates for the core and the peripherals.
  // idle stops core
  assign o_cpu_clk_en = (mode_ff == wpr_pkg::WPR_RUN);
  assign o_periph_clk_en = (mode_ff != wpr_pkg::WPR_PDOWN);

  // APB decode; no wait states, unmapped access answers with an error.
  assign setup = i_apb_req.psel && !i_apb_req.penable;
  assign access = i_apb_req.psel && i_apb_req.penable;
  assign power_control_hit = (i_apb_req.paddr == wpr_pkg::POWER_CONTROL_ADDR);
  assign watchdog_control_hit = (i_apb_req.paddr == wpr_pkg::WATCHDOG_CONTROL_ADDR);
  assign wr_power_control = access && i_apb_req.pwrite && power_control_hit;
  assign wr_watchdog_control = access && i_apb_req.pwrite && watchdog_control_hit;
  assign wr_watchdog_control_val = wpr_pkg::wpr_watchdog_control_type'(i_apb_req.pwdata[7:0]);
  assign wr_power_control_val = wpr_pkg::wpr_power_control_type'(i_apb_req.pwdata[7:0]);
  assign rd_val = power_control_hit ? power_control_ff : watchdog_control_hit ? watchdog_control_ff : 8'h00;

  // Watchdog control: a written clear wins over its own self-clear.
  // disabled on reset
  always_comb begin
    nxt_watchdog_control = watchdog_control_ff;
    nxt_watchdog_control.wdog_clear_bit = watchdog_control_ff.wdog_clear_bit && !mc_tick;
    if (wr_watchdog_control) begin
      nxt_watchdog_control = wr_watchdog_control_val;
      nxt_watchdog_control.rsv = 2'h0;
      nxt_watchdog_control.wdog_clear_bit = wr_watchdog_control_val.wdog_clear_bit || nxt_watchdog_control.wdog_clear_bit;
      if (!wr_watchdog_control_val.wdog_clear_bit) begin
        nxt_watchdog_control.wdog_clear_bit = watchdog_control_ff.wdog_clear_bit && !mc_tick;
      end
    end
    if (sys_rst_ff) begin
      nxt_watchdog_control = wpr_pkg::WATCHDOG_CONTROL_RST;
    end
  end

  // Power control: idle bit drops on wake, power-off flag only clears.
  // flag survives warm reset
  always_comb begin
    nxt_power_control = power_control_ff;
    if (idle_exit) begin
      nxt_power_control.idle_bit = 1'b0;
    end
    if (wr_power_control) begin
      nxt_power_control = wr_power_control_val;
      nxt_power_control.rsv = 3'h0;
      nxt_power_control.power_off_flag = power_control_ff.power_off_flag && wr_power_control_val.power_off_flag;
    end
    if (sys_rst_ff) begin
      nxt_power_control = wpr_pkg::wpr_power_control_type'(wpr_pkg::SFR_RST);
      nxt_power_control.power_off_flag = power_control_ff.power_off_flag;
    end
  end

  // Registers, written in the access phase, and read data captured in the setup phase.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      watchdog_control_ff <= wpr_pkg::WATCHDOG_CONTROL_RST;
      power_control_ff <= wpr_pkg::POWER_CONTROL_POR;
      prdata_ff <= 32'h0000_0000;
    end else begin
      watchdog_control_ff <= nxt_watchdog_control;
      power_control_ff <= nxt_power_control;
      prdata_ff <= setup ? {24'h00_0000, rd_val} : prdata_ff;
    end
  end

  // Outputs.
  assign o_apb_rsp.prdata = prdata_ff;
  assign o_apb_rsp.pready = 1'b1;
  assign o_apb_rsp.pslverr = access && !(power_control_hit || watchdog_control_hit);
  assign o_mc_tick = mc_tick;
  assign o_sys_rst = sys_rst_ff;
  assign o_wdt_timeout = to_ff;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  property p_wdt_off_after_rst;
    sys_rst_ff |=> !watchdog_control_ff.wdog_enable_bit;
  endproperty
  a_wdt_off_after_rst: assert property (p_wdt_off_after_rst) else $error("watchdog enabled after reset");

  property p_hold_disabled;
    !watchdog_control_ff.wdog_enable_bit && !watchdog_control_ff.wdog_clear_bit && !sys_rst_ff
      |=> $stable(timer_ff) && $stable(pre_ff);
  endproperty
  a_hold_disabled: assert property (p_hold_disabled) else $error("disabled watchdog moved");

  property p_timeout_rst;
    wdt_to |=> wdt_rst_ff ##1 sys_rst_ff ##1 !watchdog_control_ff.wdog_enable_bit;
  endproperty
  a_timeout_rst: assert property (p_timeout_rst) else $error("time-out did not reset");

  property p_pre_wrap;
    pre_wrap && !watchdog_control_ff.wdog_clear_bit && !sys_rst_ff
      |=> pre_ff == 8'h00 && timer_ff == $past(timer_ff) + 14'h0001;
  endproperty
  a_pre_wrap: assert property (p_pre_wrap) else $error("timer did not step on prescale wrap");

  property p_clear_self;
    clr_do && !wr_watchdog_control |=> !watchdog_control_ff.wdog_clear_bit && timer_ff == '0 && pre_ff == '0;
  endproperty
  a_clear_self: assert property (p_clear_self) else $error("clear bit did not act");

  property p_idle_stop;
    mode_ff == wpr_pkg::WPR_IDLE && !watchdog_control_ff.wdog_run_in_idle && !watchdog_control_ff.wdog_clear_bit && !sys_rst_ff
      |=> $stable(timer_ff);
  endproperty
  a_idle_stop: assert property (p_idle_stop) else $error("watchdog ran in idle");

  property p_div2;
    $past(i_rst_b) && o_osc_run && $past(o_osc_run) |-> phase_ff != $past(phase_ff);
  endproperty
  a_div2: assert property (p_div2) else $error("divider did not toggle");

  property p_idle_clk;
    mode_ff == wpr_pkg::WPR_IDLE |-> !o_cpu_clk_en && o_periph_clk_en;
  endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("idle clock gating wrong");

  property p_idle_exit;
    idle_exit |=> mode_ff == wpr_pkg::WPR_RUN && !power_control_ff.idle_bit;
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("interrupt did not end idle");

  property p_pd_stay;
    mode_ff == wpr_pkg::WPR_PDOWN && !sys_rst_ff |=> mode_ff == wpr_pkg::WPR_PDOWN;
  endproperty
  a_pd_stay: assert property (p_pd_stay) else $error("power-down left without reset");

  property p_pof_keep;
    sys_rst_ff && !wr_power_control |=> $stable(power_control_ff.power_off_flag);
  endproperty
  a_pof_keep: assert property (p_pof_keep) else $error("power-off flag lost on reset");

  property p_pin_rst;
    $rose(pin_rst) |-> $past(pin_sync_ff) && $past(sample);
  endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("pin reset without sample");

  // Main scenarios.
  c_timeout: cover property (wdt_to);
  c_idle_wake: cover property (idle_exit);
  c_pd_wake: cover property (mode_ff == wpr_pkg::WPR_PDOWN ##1 sys_rst_ff);
  c_clear: cover property (clr_do && watchdog_control_ff.wdog_enable_bit);
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
/*
  Self-checking bench for the watchdog, power and reset block.
  Assumes zero-wait APB answers and a 12-clock machine cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic i_ref_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_rst_pin = 1'b0;
  logic i_irq_pend = 1'b0;
  wpr_pkg::wpr_apb_req_type req = '0;
  wpr_pkg::wpr_apb_rsp_type rsp;
  logic osc_run, cpu_en, per_en, mc_tick, sys_rst, wdt_to, slv;
  logic [31:0] rd;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  int rst_rises = 0;
  int to_pulses = 0;
  int n;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} wpr_row_type;
  wpr_row_type rows[10];

  // The oscillator clock, 25 ns period.
  always #12.5 i_ref_clk = ~i_ref_clk;

  wpr_watchdog_power_reset i_dut (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_apb_req(req), .o_apb_rsp(rsp),
    .i_rst_pin(i_rst_pin), .i_irq_pend(i_irq_pend), .o_osc_run(osc_run),
    .o_cpu_clk_en(cpu_en), .o_periph_clk_en(per_en), .o_mc_tick(mc_tick),
    .o_sys_rst(sys_rst), .o_wdt_timeout(wdt_to)
  );

  // Counts system reset rises and time-out pulses; cuts a hang short.
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (sys_rst === 1'b1 && $past(sys_rst) === 1'b0) rst_rises <= rst_rises + 1;
    if (wdt_to === 1'b1) to_pulses <= to_pulses + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // One APB transfer; read data and error taken at the pready edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge i_ref_clk);
    req.penable <= 1'b1;
    do @(posedge i_ref_clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    slv = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  initial begin
    rows = '{
      '{wpr_pkg::POWER_CONTROL_ADDR, 32'h1c, 32'h1c, 1'b0}, '{wpr_pkg::POWER_CONTROL_ADDR, 32'habcd0004, 32'h04, 1'b0},
      '{wpr_pkg::POWER_CONTROL_ADDR, 32'h18, 32'h08, 1'b0}, '{wpr_pkg::WATCHDOG_CONTROL_ADDR, 32'h07, 32'h07, 1'b0},
      '{wpr_pkg::WATCHDOG_CONTROL_ADDR, 32'h23, 32'h23, 1'b0}, '{wpr_pkg::WATCHDOG_CONTROL_ADDR, 32'h1a, 32'h02, 1'b0},
      '{wpr_pkg::WATCHDOG_CONTROL_ADDR, 32'h85, 32'h85, 1'b0}, '{wpr_pkg::WATCHDOG_CONTROL_ADDR, 32'h00, 32'h00, 1'b0},
      '{12'h220, 32'hff, 32'h00, 1'b1}, '{12'h000, 32'h10, 32'h00, 1'b1}};
    repeat (6) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    @(posedge i_ref_clk);
    check({sys_rst, wdt_to, cpu_en, per_en, osc_run}, 32'h07);
    rd_chk(wpr_pkg::POWER_CONTROL_ADDR, 32'h10);
    rd_chk(wpr_pkg::WATCHDOG_CONTROL_ADDR, 32'h00);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      check(slv, rows[i].e);
      apb(1'b0, rows[i].a, 32'h0);
      check(rd, rows[i].q);
      check(slv, rows[i].e);
    end
    n = 0;
    while (mc_tick !== 1'b1 && n < 40) begin
      @(posedge i_ref_clk);
      n++;
    end
    n = 0;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (mc_tick !== 1'b1 && n < 40);
    check(n, wpr_pkg::OSC_PER_MC);
    // clear bit self-clears within a machine cycle
    apb(1'b1, wpr_pkg::WATCHDOG_CONTROL_ADDR, 32'hc0);
    repeat (14) @(posedge i_ref_clk);
    rd_chk(wpr_pkg::WATCHDOG_CONTROL_ADDR, 32'h80);
    apb(1'b1, wpr_pkg::WATCHDOG_CONTROL_ADDR, 32'h00);
    // idle stops the core clock only
    apb(1'b1, wpr_pkg::POWER_CONTROL_ADDR, 32'h09);
    repeat (2) @(posedge i_ref_clk);
    check({cpu_en, per_en, osc_run}, 32'h3);
    i_irq_pend <= 1'b1;
    @(posedge i_ref_clk);
    i_irq_pend <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    check(cpu_en, 1'b1);
    rd_chk(wpr_pkg::POWER_CONTROL_ADDR, 32'h08);
    // a short pin pulse is ignored
    i_rst_pin <= 1'b1;
    repeat (5) @(posedge i_ref_clk);
    i_rst_pin <= 1'b0;
    repeat (40) @(posedge i_ref_clk);
    check(rst_rises, 0);
    apb(1'b1, wpr_pkg::POWER_CONTROL_ADDR, 32'h0e);
    repeat (2) @(posedge i_ref_clk);
    check({cpu_en, per_en, osc_run}, 32'h0);
    i_irq_pend <= 1'b1;
    repeat (30) @(posedge i_ref_clk);
    i_irq_pend <= 1'b0;
    check({cpu_en, osc_run}, 32'h0);
    // a held pin resets the device
    i_rst_pin <= 1'b1;
    n = 0;
    while (sys_rst !== 1'b1 && n < 100) begin
      @(posedge i_ref_clk);
      n++;
    end
    check(sys_rst, 1'b1);
    i_rst_pin <= 1'b0;
    n = 0;
    while (sys_rst !== 1'b0 && n < 100) begin
      @(posedge i_ref_clk);
      n++;
    end
    @(posedge i_ref_clk);
    check({sys_rst, cpu_en, per_en, osc_run}, 32'h7);
    check(rst_rises, 1);
    rd_chk(wpr_pkg::POWER_CONTROL_ADDR, 32'h00);
    rd_chk(wpr_pkg::WATCHDOG_CONTROL_ADDR, 32'h00);
    // power-on reset sets the flag again
    @(posedge i_ref_clk);
    i_rst_b <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    @(posedge i_ref_clk);
    rd_chk(wpr_pkg::POWER_CONTROL_ADDR, 32'h10);
    check(to_pulses, 0);
    print_verdict();
  end
endmodule
`default_nettype wire
